// ---- src/ppp_protect_ctrl.v ----
// gate between the serial programming port, the cpu table path and the memories
// What this block does
// RL1: read protect active blocks every external data-eeprom read and write.
// RL2: write protect active blocks external data-eeprom writes only.
// RL3: cpu data-eeprom reads and writes ignore both eeprom protect bits.
// RL4: running code cannot change the config write protect bit.
// RL5: config write protect changes only from programmer; when active blocks config writes.
// RL6: eight id words 200000h-200007h readable and writable by cpu and programmer.
// RL7: id words stay readable externally under code protection.
// RL8: debugger enabled when the debug config bit is 0.
// RL9: debugger holds both port pins, 2 stack levels, 512 pm and 10 dm bytes.
// RL10: bit 2 of config byte 4 low is the low-voltage program enable.
// RL11: with low-voltage enable set, entry pin is not general-purpose io.
// RL12: erased configuration has low-voltage enable at 1.
// RL13: supply on master clear plus entry pin high enters programming mode.
// RL14: high voltage on master clear always enters programming mode.
// RL15: outside circuit holds entry pin low for normal running.
// RL16: low-voltage enable changes only in a high-voltage session.
// RL17: low-voltage enable cleared: entry pin ignored and freed as io.
// RL18: protected memory erases only by block erase; row erase refused.
// RL19: link uses port bit 6 as clock and port bit 7 as data.
// RL20: protection bits write 1 to 0 only; block erase restores 1.
// RL21: refused external read returns zero; refused write changes nothing.
`timescale 1ns/1ps
`include "ppp_defs.vh"
module ppp_protect_ctrl #(
  parameter ADDR_W = `PPP_ADDR_W,
  parameter DATA_W = 8
) (
  input wire mclk,
  input wire rst_n,
  // link pins, port bit 6 clock and port bit 7 data
  input wire progSerialClock,
  input wire progSerialDataIn,
  output reg progSerialDataOut_r,
  output reg progSerialDataOe_n_r,
  // master clear comparators and entry pin
  input wire mclrHighVoltage,
  input wire mclrAtSupply,
  input wire progModeEntryPin,
  // decoded programmer requests
  input wire extReq,
  input wire [1:0] extOp,
  input wire [1:0] extTgt,
  input wire [ADDR_W-1:0] extAddr,
  input wire [DATA_W-1:0] extWdata,
  output reg extDone_r,
  output reg extRefused_r,
  output reg [DATA_W-1:0] extRdData_r,
  // cpu table and eeprom requests
  input wire cpuReq,
  input wire cpuWrite,
  input wire cpuEe,
  input wire [ADDR_W-1:0] cpuAddr,
  input wire [DATA_W-1:0] cpuWdata,
  output reg cpuCfgDone_r,
  output reg [DATA_W-1:0] cpuCfgRdData_r,
  // memory side
  output reg memRdEn_r,
  output reg memWrEn_r,
  output reg memRowErase_r,
  output reg memBlockErase_r,
  output reg memSrcExt_r,
  output reg [1:0] memTgt_r,
  output reg [ADDR_W-1:0] memAddr_r,
  output reg [DATA_W-1:0] memWdata_r,
  input wire memRdValid,
  input wire [DATA_W-1:0] memRdData,
  // status
  output reg progMode_r,
  output reg hvSession_r,
  output reg lowVoltProgEnable_r,
  output reg entryPinIsGpio_r,
  output reg debugEnable_r,
  output reg debugPinsReserved_r,
  output reg [1:0] debugStackLevels_r,
  output reg [9:0] debugPmBytes_r,
  output reg [3:0] debugDmBytes_r,
  output reg progSerialDataIn_r
);
  localparam IDLE = 2'h0;
  localparam WAIT_RD = 2'h1;

  wire [3:0] pinSync;
  wire modeProg;
  wire modeHv;
  wire linkClk;
  reg linkClkDly_r;
  wire linkRise;
  reg [`PPP_STATE_W-1:0] state_r;
  reg [DATA_W-1:0] shift_r;
  reg [3:0] bitCnt_r;
  wire [8*`PPP_CFG_COUNT-1:0] cfgFlat;
  wire [7:0] cfg4l;
  wire [7:0] cfg5l;
  wire [7:0] cfg5h;
  wire [7:0] cfg6h;
  wire lowVoltBit;
  wire entrySync;
  wire eeRdProt;
  wire eeWrProt;
  wire cfgWrProt;
  wire codeProt;
  wire extTake;
  wire cpuTake;
  wire extIsId;
  wire extCfgHit;
  wire [`PPP_CFG_IDX_W-1:0] extCfgIdx;
  wire cpuCfgHit;
  wire [`PPP_CFG_IDX_W-1:0] cpuCfgIdx;
  wire cpuIdHit;
  reg extAllow;
  wire extCfgWrite;
  wire cpuCfgWrite;
  wire blockErase;
  wire [7:0] extCfgRd;
  wire [7:0] cpuCfgRd;

  ppp_sync #(.WIDTH(4)) u_pinSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn({progSerialDataIn, progSerialClock, mclrHighVoltage, mclrAtSupply}),
    .syncOut_r(pinSync)
  );

  assign linkClk = pinSync[2]; // RL19

  ppp_mode_ctrl u_mode (
    .mclk(mclk),
    .rst_n(rst_n),
    .hvDetect(pinSync[1]),
    .mclrAtSupply(pinSync[0]),
    .progEntryPin(entrySync),
    .lowVoltProgEnable(lowVoltBit),
    .progMode_r(modeProg),
    .hvSession_r(modeHv)
  );

  // entry pin synchronised on its own so it can be ignored cleanly when freed
  ppp_sync #(.WIDTH(1)) u_entrySync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(progModeEntryPin),
    .syncOut_r(entrySync)
  );

  // configuration fields; protect and debug bits active low as fuses, low-voltage enable active high
  assign cfg4l = cfgFlat[8*`PPP_CFG4L_IDX +: 8];
  assign cfg5l = cfgFlat[8*`PPP_CFG5L_IDX +: 8];
  assign cfg5h = cfgFlat[8*`PPP_CFG5H_IDX +: 8];
  assign cfg6h = cfgFlat[8*`PPP_CFG6H_IDX +: 8];
  assign lowVoltBit = cfg4l[`PPP_LOWVOLT_BIT]; // RL10
  assign eeRdProt = ~cfg5h[`PPP_EERD_BIT];
  assign eeWrProt = ~cfg6h[`PPP_EEWR_BIT];
  assign cfgWrProt = ~cfg6h[`PPP_CFGWR_BIT];
  assign codeProt = ~(&cfg5l[`PPP_CP_MSB:`PPP_CP_LSB]) | ~cfg5h[`PPP_BOOTCP_BIT];

  // cpu runs only outside programming mode; programmer only inside it
  assign extTake = extReq & (state_r == IDLE);
  assign cpuTake = cpuReq & ~modeProg;

  assign extIsId = (extAddr >= `PPP_ID_FIRST) && (extAddr <= `PPP_ID_LAST);
  assign extCfgHit = (extTgt == `PPP_TGT_CFG) &&
    (extAddr >= `PPP_CFG_FIRST) && (extAddr <= `PPP_CFG_LAST);
  assign extCfgIdx = extAddr[`PPP_CFG_IDX_W-1:0];
  assign cpuCfgHit = ~cpuEe && (cpuAddr >= `PPP_CFG_FIRST) && (cpuAddr <= `PPP_CFG_LAST);
  assign cpuCfgIdx = cpuAddr[`PPP_CFG_IDX_W-1:0];
  assign cpuIdHit = ~cpuEe && (cpuAddr >= `PPP_ID_FIRST) && (cpuAddr <= `PPP_ID_LAST);

  always @* begin
    extAllow = modeProg;
    case (extTgt)
      `PPP_TGT_EE: begin
        if (eeRdProt) begin
          extAllow = 1'b0; // RL1
        end else if ((extOp != `PPP_OP_READ) && eeWrProt) begin
          extAllow = 1'b0; // RL2
        end
      end
      `PPP_TGT_CFG: begin
        if (!extCfgHit) begin
          extAllow = 1'b0;
        end else if ((extOp != `PPP_OP_READ) && cfgWrProt) begin
          extAllow = 1'b0; // RL5
        end
      end
      `PPP_TGT_ID: begin
        // id words ignore code protection for reads
        if (!extIsId) begin
          extAllow = 1'b0; // RL6 RL7
        end
      end
      `PPP_TGT_PM: begin
        if ((extOp == `PPP_OP_ROW_ERASE) && codeProt) begin
          extAllow = 1'b0; // RL18
        end else if ((extOp == `PPP_OP_READ || extOp == `PPP_OP_WRITE) && codeProt) begin
          extAllow = 1'b0;
        end
      end
      default: begin
        extAllow = 1'b0;
      end
    endcase
    // block erase is the only way back from protection, so it is refused only outside programming mode
    if (extOp == `PPP_OP_BLOCK_ERASE) begin
      extAllow = modeProg; // RL18 RL20
    end
  end

  assign extCfgWrite = extTake & extAllow & (extOp == `PPP_OP_WRITE) & extCfgHit; // RL5
  // cpu can never write protection bytes, so the config lock stays read-only to code
  assign cpuCfgWrite = cpuTake & cpuWrite & cpuCfgHit & ~cfgWrProt &
    (cpuCfgIdx < `PPP_PROT_FIRST_IDX); // RL4
  assign blockErase = extTake & modeProg & (extOp == `PPP_OP_BLOCK_ERASE); // RL20
  assign extCfgRd = cfgFlat[8*extCfgIdx +: 8];
  assign cpuCfgRd = cfgFlat[8*cpuCfgIdx +: 8];

  // configuration storage, erased state is all ones
  genvar gi;
  generate
    for (gi = 0; gi < `PPP_CFG_COUNT; gi = gi + 1) begin : g_cfg
      reg [7:0] cfgByte_r;
      reg [7:0] cfgByte_nxt;
      always @* begin
        cfgByte_nxt = cfgByte_r;
        if (blockErase) begin
          cfgByte_nxt = `PPP_ERASED_BYTE; // RL20
        end else if (extCfgWrite && (extCfgIdx == gi)) begin
          if (gi >= `PPP_PROT_FIRST_IDX) begin
            cfgByte_nxt = cfgByte_r & extWdata; // RL20
          end else begin
            cfgByte_nxt = extWdata;
          end
          if ((gi == `PPP_CFG4L_IDX) && !modeHv) begin
            cfgByte_nxt[`PPP_LOWVOLT_BIT] = cfgByte_r[`PPP_LOWVOLT_BIT]; // RL16
          end
        end else if (cpuCfgWrite && (cpuCfgIdx == gi)) begin
          cfgByte_nxt = cpuWdata;
          if (gi == `PPP_CFG4L_IDX) begin
            cfgByte_nxt[`PPP_LOWVOLT_BIT] = cfgByte_r[`PPP_LOWVOLT_BIT]; // RL16
          end
        end
      end
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cfgByte_r <= `PPP_ERASED_BYTE; // RL12
        end else begin
          cfgByte_r <= cfgByte_nxt;
        end
      end
      assign cfgFlat[8*gi +: 8] = cfgByte_r;
    end
  endgenerate

  // request handling and memory strobes
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      extDone_r <= 1'b0;
      extRefused_r <= 1'b0;
      extRdData_r <= `PPP_ZERO_BYTE;
      cpuCfgDone_r <= 1'b0;
      cpuCfgRdData_r <= `PPP_ZERO_BYTE;
      memRdEn_r <= 1'b0;
      memWrEn_r <= 1'b0;
      memRowErase_r <= 1'b0;
      memBlockErase_r <= 1'b0;
      memSrcExt_r <= 1'b0;
      memTgt_r <= `PPP_TGT_EE;
      memAddr_r <= {ADDR_W{1'b0}};
      memWdata_r <= `PPP_ZERO_BYTE;
    end else begin
      extDone_r <= 1'b0;
      extRefused_r <= 1'b0;
      cpuCfgDone_r <= 1'b0;
      memRdEn_r <= 1'b0;
      memWrEn_r <= 1'b0;
      memRowErase_r <= 1'b0;
      memBlockErase_r <= 1'b0;
      case (state_r)
        IDLE: begin
          if (extTake) begin
            if (!extAllow) begin
              // refused: no strobe reaches memory, reads give zero
              extDone_r <= 1'b1;
              extRefused_r <= 1'b1;
              extRdData_r <= `PPP_ZERO_BYTE; // RL21
            end else if ((extTgt == `PPP_TGT_CFG) && (extOp != `PPP_OP_BLOCK_ERASE)) begin
              extDone_r <= 1'b1;
              extRdData_r <= (extOp == `PPP_OP_READ) ? extCfgRd : `PPP_ZERO_BYTE;
            end else begin
              memSrcExt_r <= 1'b1;
              memTgt_r <= extTgt;
              memAddr_r <= extAddr;
              memWdata_r <= extWdata;
              memRdEn_r <= (extOp == `PPP_OP_READ);
              memWrEn_r <= (extOp == `PPP_OP_WRITE);
              memRowErase_r <= (extOp == `PPP_OP_ROW_ERASE);
              memBlockErase_r <= (extOp == `PPP_OP_BLOCK_ERASE);
              if (extOp == `PPP_OP_READ) begin
                state_r <= WAIT_RD;
              end else begin
                extDone_r <= 1'b1;
                extRdData_r <= `PPP_ZERO_BYTE;
              end
            end
          end else if (cpuTake) begin
            if (cpuCfgHit) begin
              cpuCfgDone_r <= 1'b1;
              cpuCfgRdData_r <= cpuCfgRd; // RL4
            end else begin
              // cpu eeprom path bypasses the eeprom protect bits
              memSrcExt_r <= 1'b0;
              memTgt_r <= cpuEe ? `PPP_TGT_EE : (cpuIdHit ? `PPP_TGT_ID : `PPP_TGT_PM); // RL3 RL6
              memAddr_r <= cpuAddr;
              memWdata_r <= cpuWdata;
              memRdEn_r <= ~cpuWrite;
              memWrEn_r <= cpuWrite;
            end
          end
        end
        WAIT_RD: begin
          if (memRdValid) begin
            extDone_r <= 1'b1;
            extRdData_r <= memRdData;
            state_r <= IDLE;
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  // read data goes out lsb first, one bit per link clock rise
  assign linkRise = linkClk & ~linkClkDly_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linkClkDly_r <= 1'b0;
      shift_r <= `PPP_ZERO_BYTE;
      bitCnt_r <= 4'h0;
      progSerialDataOut_r <= 1'b0;
      progSerialDataOe_n_r <= 1'b1;
      progSerialDataIn_r <= 1'b0;
    end else begin
      linkClkDly_r <= linkClk;
      progSerialDataIn_r <= pinSync[3];
      if (extDone_r && !modeProg) begin
        bitCnt_r <= 4'h0;
        progSerialDataOe_n_r <= 1'b1;
      end else if (extDone_r && (state_r == IDLE)) begin
        // a newer answer replaces a byte the programmer never clocked out
        shift_r <= extRdData_r;
        bitCnt_r <= `PPP_BIT_COUNT;
      end else if (linkRise && (bitCnt_r != 4'h0)) begin
        progSerialDataOut_r <= shift_r[0]; // RL19
        progSerialDataOe_n_r <= 1'b0;
        shift_r <= {1'b0, shift_r[DATA_W-1:1]};
        bitCnt_r <= bitCnt_r - 4'h1;
      end else if (linkRise) begin
        progSerialDataOe_n_r <= 1'b1;
      end
      if (!modeProg) begin
        progSerialDataOe_n_r <= 1'b1;
      end
    end
  end

  // status and debugger reservations
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progMode_r <= 1'b0;
      hvSession_r <= 1'b0;
      lowVoltProgEnable_r <= 1'b1;
      entryPinIsGpio_r <= 1'b0;
      debugEnable_r <= 1'b0;
      debugPinsReserved_r <= 1'b0;
      debugStackLevels_r <= 2'h0;
      debugPmBytes_r <= 10'h000;
      debugDmBytes_r <= 4'h0;
    end else begin
      progMode_r <= modeProg;
      hvSession_r <= modeHv;
      lowVoltProgEnable_r <= lowVoltBit;
      entryPinIsGpio_r <= ~lowVoltBit; // RL11 RL17
      debugEnable_r <= ~cfg4l[`PPP_DEBUG_BIT]; // RL8
      debugPinsReserved_r <= ~cfg4l[`PPP_DEBUG_BIT]; // RL9
      debugStackLevels_r <= cfg4l[`PPP_DEBUG_BIT] ? 2'h0 : `PPP_DBG_STACK_LEVELS; // RL9
      debugPmBytes_r <= cfg4l[`PPP_DEBUG_BIT] ? 10'h000 : `PPP_DBG_PM_BYTES; // RL9
      debugDmBytes_r <= cfg4l[`PPP_DEBUG_BIT] ? 4'h0 : `PPP_DBG_DM_BYTES; // RL9
    end
  end
endmodule // ppp_protect_ctrl

// ---- common/ppp_defs.vh ----
// constants for the programming-port protection controller
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH

// external operations
`define PPP_OP_READ 2'h0
`define PPP_OP_WRITE 2'h1
`define PPP_OP_ROW_ERASE 2'h2
`define PPP_OP_BLOCK_ERASE 2'h3

// memory targets
`define PPP_TGT_EE 2'h0
`define PPP_TGT_CFG 2'h1
`define PPP_TGT_ID 2'h2
`define PPP_TGT_PM 2'h3

// table address map
`define PPP_ADDR_W 22
`define PPP_ID_FIRST 22'h200000
`define PPP_ID_LAST 22'h200007
`define PPP_CFG_FIRST 22'h300000
`define PPP_CFG_LAST 22'h30000D
`define PPP_CFG_IDX_W 4
`define PPP_CFG_COUNT 14

// configuration byte indices (offset from the config base)
`define PPP_CFG4L_IDX 4'h6
`define PPP_CFG5L_IDX 4'h8
`define PPP_CFG5H_IDX 4'h9
`define PPP_CFG6H_IDX 4'hB
`define PPP_PROT_FIRST_IDX 4'h8

// bit positions
`define PPP_LOWVOLT_BIT 2
`define PPP_DEBUG_BIT 7
`define PPP_EERD_BIT 7
`define PPP_BOOTCP_BIT 6
`define PPP_EEWR_BIT 7
`define PPP_CFGWR_BIT 5
`define PPP_CP_LSB 0
`define PPP_CP_MSB 3

`define PPP_ERASED_BYTE 8'hFF
`define PPP_ZERO_BYTE 8'h00

// resources held by the debugger
`define PPP_DBG_STACK_LEVELS 2'h2
`define PPP_DBG_PM_BYTES 10'h200
`define PPP_DBG_DM_BYTES 4'hA

`define PPP_BIT_COUNT 4'h8
`define PPP_STATE_W 2

`endif

// ---- src/ppp_sync.v ----
// two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
module ppp_sync #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut_r
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      syncOut_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= asyncIn;
      syncOut_r <= meta_r;
    end
  end
endmodule // ppp_sync

// ---- src/ppp_mode_ctrl.v ----
// programming-mode entry: high-voltage and low-voltage sessions
`timescale 1ns/1ps
`include "ppp_defs.vh"
module ppp_mode_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire hvDetect,
  input wire mclrAtSupply,
  input wire progEntryPin,
  input wire lowVoltProgEnable,
  output reg progMode_r,
  output reg hvSession_r
);
  localparam RUN = 2'h0;
  localparam LV_PROG = 2'h1;
  localparam HV_PROG = 2'h2;

  reg [`PPP_STATE_W-1:0] state_r;
  reg [`PPP_STATE_W-1:0] state_nxt;
  wire lvEntry;

  // entry pin counts only while low-voltage entry is enabled
  assign lvEntry = lowVoltProgEnable & mclrAtSupply & progEntryPin; // RL13 RL17

  always @* begin
    state_nxt = state_r;
    case (state_r)
      RUN: begin
        if (hvDetect) begin
          state_nxt = HV_PROG; // RL14
        end else if (lvEntry) begin
          state_nxt = LV_PROG; // RL13
        end
      end
      LV_PROG: begin
        // high voltage always takes over a low-voltage session
        if (hvDetect) begin
          state_nxt = HV_PROG; // RL14
        end else if (!lvEntry) begin
          state_nxt = RUN;
        end
      end
      HV_PROG: begin
        if (!hvDetect) begin
          state_nxt = RUN;
        end
      end
      default: begin
        state_nxt = RUN;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RUN;
      progMode_r <= 1'b0;
      hvSession_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      progMode_r <= (state_nxt != RUN);
      hvSession_r <= (state_nxt == HV_PROG);
    end
  end
endmodule // ppp_mode_ctrl

// ---- tb/ppp_protect_ctrl_properties.sv ----
// port-level assertions for the programming-port protection controller
`timescale 1ns/1ps
module ppp_protect_ctrl_properties #(
  parameter DATA_W = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire extReq,
  input wire mclrHighVoltage,
  input wire memRdValid,
  input wire extDone_r,
  input wire extRefused_r,
  input wire [DATA_W-1:0] extRdData_r,
  input wire memRdEn_r,
  input wire memWrEn_r,
  input wire memSrcExt_r,
  input wire progMode_r,
  input wire hvSession_r,
  input wire lowVoltProgEnable_r,
  input wire entryPinIsGpio_r,
  input wire debugEnable_r,
  input wire debugPinsReserved_r,
  input wire [1:0] debugStackLevels_r,
  input wire [9:0] debugPmBytes_r,
  input wire [3:0] debugDmBytes_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // held long enough to cover the pin synchroniser and mode register
  sequence s_hvHeld; mclrHighVoltage [*8]; endsequence
  sequence s_lvOff; (!lowVoltProgEnable_r && !mclrHighVoltage) [*8]; endsequence
  sequence s_extAns; memRdValid && memSrcExt_r; endsequence
  property p_refusedEmpty; extRefused_r |-> extDone_r && extRdData_r == 0; endproperty
  property p_noModeNoMem;
    extReq && !progMode_r |=> extRefused_r && !memRdEn_r && !memWrEn_r;
  endproperty
  property p_extAnswer; s_extAns |=> extDone_r; endproperty
  property p_hvEnters; s_hvHeld |-> progMode_r && hvSession_r; endproperty
  property p_lvIgnored; s_lvOff |-> !progMode_r; endproperty
  property p_lowVoltOnlyHv; $changed(lowVoltProgEnable_r) |-> $past(hvSession_r); endproperty
  // one cycle of slack in case the pin flag lags the enable
  property p_gpioTaken;
    lowVoltProgEnable_r && $past(lowVoltProgEnable_r) |-> !entryPinIsGpio_r;
  endproperty
  property p_debugRes;
    debugEnable_r |-> debugPinsReserved_r && debugStackLevels_r == 2'h2
      && debugPmBytes_r == 10'h200 && debugDmBytes_r == 4'hA;
  endproperty
  property p_debugIdle; !debugEnable_r |-> debugPmBytes_r == 10'h000 && !debugPinsReserved_r;
  endproperty
  a_refusedEmpty: assert property (p_refusedEmpty) else $error("refused answer not empty");
  a_noModeNoMem: assert property (p_noModeNoMem) else $error("request passed outside mode");
  a_extAnswer: assert property (p_extAnswer) else $error("read answer missing");
  a_hvEnters: assert property (p_hvEnters) else $error("high voltage did not enter");
  a_lvIgnored: assert property (p_lvIgnored) else $error("entry pin not ignored");
  a_lowVoltOnlyHv: assert property (p_lowVoltOnlyHv) else $error("enable changed outside hv");
  a_gpioTaken: assert property (p_gpioTaken) else $error("entry pin left as io");
  a_debugRes: assert property (p_debugRes) else $error("debug resources wrong");
  a_debugIdle: assert property (p_debugIdle) else $error("debug resources held");
endmodule // ppp_protect_ctrl_properties

bind ppp_protect_ctrl ppp_protect_ctrl_properties #(.DATA_W(DATA_W)) chk_u (
  .mclk, .rst_n, .extReq, .mclrHighVoltage, .memRdValid, .extDone_r, .extRefused_r,
  .extRdData_r, .memRdEn_r, .memWrEn_r, .memSrcExt_r, .progMode_r, .hvSession_r,
  .lowVoltProgEnable_r, .entryPinIsGpio_r, .debugEnable_r, .debugPinsReserved_r,
  .debugStackLevels_r, .debugPmBytes_r, .debugDmBytes_r
);

// ---- tb/ppp_prog_model.sv ----
// serial programmer model: link clock within frames, shared data line
`timescale 1ns/1ps
module ppp_prog_model (
  input wire devOut,
  input wire devOe_n,
  output reg linkClk,
  output wire dataLine
);
  reg lastLvl;
  // released line floats: show the inverse so a stale bit never matches
  assign dataLine = devOe_n ? ~lastLvl : devOut;
  always @(devOut or devOe_n) begin
    if (!devOe_n)
      lastLvl = devOut;
  end
  initial begin
    linkClk = 1'b0;
    lastLvl = 1'b0;
  end
  task frame(output [7:0] b, output oeLow, output oeRel);
    integer i;
    begin
      oeLow = 1'b1;
      for (i = 0; i < 9; i = i + 1) begin
        #40 linkClk = 1'b1;
        #40 linkClk = 1'b0;
        if (i < 8) begin
          b[i] = dataLine;
          oeLow = oeLow & ~devOe_n;
        end
      end
      oeRel = devOe_n;
    end
  endtask
endmodule // ppp_prog_model

// ---- tb/ppp_protect_ctrl_test.sv ----
// self-checking bench for the programming-port protection controller
`timescale 1ns/1ps
module ppp_protect_ctrl_test;
  reg mclk = 1'b0, rst_n = 1'b0, mclrHighVoltage = 1'b0, mclrAtSupply = 1'b1;
  reg progModeEntryPin = 1'b0, extReq = 1'b0, cpuReq = 1'b0, cpuWrite = 1'b0;
  reg cpuEe = 1'b0, memRdValid = 1'b0, srcExt = 1'b1, oeLow, oeRel;
  reg [1:0] extOp = 2'h0, extTgt = 2'h0;
  reg [21:0] extAddr = 22'h000000, cpuAddr = 22'h000000;
  reg [7:0] extWdata = 8'h00, cpuWdata = 8'h00, memRdData = 8'hA6, lb;
  wire progSerialClock, progSerialDataIn, progSerialDataOut_r, progSerialDataOe_n_r;
  wire extDone_r, extRefused_r, cpuCfgDone_r, memRdEn_r, memWrEn_r, memRowErase_r;
  wire memBlockErase_r, memSrcExt_r, progMode_r, hvSession_r, lowVoltProgEnable_r;
  wire entryPinIsGpio_r, debugEnable_r, debugPinsReserved_r;
  wire [7:0] extRdData_r, cpuCfgRdData_r, memWdata_r;
  wire [1:0] memTgt_r, debugStackLevels_r;
  wire [21:0] memAddr_r;
  wire [9:0] debugPmBytes_r;
  wire [3:0] debugDmBytes_r;
  integer err_count = 0, comparisons = 0, cycles = 0, wrCnt = 0, rowCnt = 0, blkCnt = 0;

  ppp_protect_ctrl dut_u (.mclk, .rst_n, .progSerialClock, .progSerialDataIn,
    .progSerialDataOut_r, .progSerialDataOe_n_r, .mclrHighVoltage, .mclrAtSupply,
    .progModeEntryPin, .extReq, .extOp, .extTgt, .extAddr, .extWdata, .extDone_r,
    .extRefused_r, .extRdData_r, .cpuReq, .cpuWrite, .cpuEe, .cpuAddr, .cpuWdata,
    .cpuCfgDone_r, .cpuCfgRdData_r, .memRdEn_r, .memWrEn_r, .memRowErase_r,
    .memBlockErase_r, .memSrcExt_r, .memTgt_r, .memAddr_r, .memWdata_r, .memRdValid,
    .memRdData, .progMode_r, .hvSession_r, .lowVoltProgEnable_r, .entryPinIsGpio_r,
    .debugEnable_r, .debugPinsReserved_r, .debugStackLevels_r, .debugPmBytes_r,
    .debugDmBytes_r, .progSerialDataIn_r());
  ppp_prog_model prog_u (.devOut(progSerialDataOut_r), .devOe_n(progSerialDataOe_n_r),
    .linkClk(progSerialClock), .dataLine(progSerialDataIn));

  always #2.5 mclk = ~mclk;
  // memory answers each read strobe in the following cycle
  always @(negedge mclk) memRdValid <= memRdEn_r;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (memWrEn_r) begin
      wrCnt <= wrCnt + 1;
      srcExt <= memSrcExt_r;
    end
    if (memRowErase_r)
      rowCnt <= rowCnt + 1;
    if (memBlockErase_r)
      blkCnt <= blkCnt + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end

  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task ext(input [1:0] op, input [1:0] tg, input [21:0] a, input [7:0] d, input rf,
    input [7:0] ex);
    integer n;
    begin
      @(negedge mclk);
      extReq = 1'b1;
      extOp = op;
      extTgt = tg;
      extAddr = a;
      extWdata = d;
      @(negedge mclk);
      extReq = 1'b0;
      n = 0;
      while (extDone_r !== 1'b1 && n < 50) begin
        @(negedge mclk);
        n = n + 1;
      end
      chk(extDone_r, 1);
      chk(extRefused_r, rf);
      if (op == 2'h0)
        chk(extRdData_r, ex);
      @(negedge mclk);
    end
  endtask
  task cpu(input w, input [21:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      cpuReq = 1'b1;
      cpuWrite = w;
      cpuEe = (a < 22'h000100);
      cpuAddr = a;
      cpuWdata = d;
      @(negedge mclk);
      cpuReq = 1'b0;
      idle(4);
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    idle(6);
    rst_n = 1'b1;
    idle(3);
    chk(lowVoltProgEnable_r, 1);
    chk(entryPinIsGpio_r, 0);
    chk(debugEnable_r, 0);
    chk(progMode_r, 0);
    ext(0, 0, 22'h000010, 0, 1, 0);
    progModeEntryPin = 1'b1;
    idle(8);
    chk({progMode_r, hvSession_r}, 2);
    ext(1, 1, 22'h300006, 8'hFB, 0, 0);
    ext(0, 1, 22'h300006, 0, 0, 8'hFF);
    progModeEntryPin = 1'b0;
    mclrHighVoltage = 1'b1;
    idle(8);
    chk({progMode_r, hvSession_r}, 3);
    ext(0, 0, 22'h000010, 0, 0, 8'hA6);
    ext(1, 0, 22'h000010, 8'h11, 0, 0);
    ext(1, 1, 22'h300009, 8'h7F, 0, 0);
    ext(0, 0, 22'h000010, 0, 1, 0);
    ext(1, 0, 22'h000010, 8'h22, 1, 0);
    chk(wrCnt, 1);
    ext(3, 0, 22'h000000, 0, 0, 0);
    chk(blkCnt, 1);
    ext(0, 1, 22'h300009, 0, 0, 8'hFF);
    ext(1, 1, 22'h30000B, 8'h7F, 0, 0);
    ext(0, 0, 22'h000010, 0, 0, 8'hA6);
    ext(1, 0, 22'h000010, 8'h33, 1, 0);
    ext(1, 1, 22'h30000B, 8'hFF, 0, 0);
    ext(0, 1, 22'h30000B, 0, 0, 8'h7F);
    ext(1, 1, 22'h300006, 8'h7F, 0, 0);
    idle(2);
    chk({debugEnable_r, debugStackLevels_r, debugDmBytes_r}, 8'h6A);
    ext(1, 1, 22'h300006, 8'h7B, 0, 0);
    idle(2);
    chk({lowVoltProgEnable_r, entryPinIsGpio_r}, 1);
    ext(1, 1, 22'h300008, 8'hF0, 0, 0);
    ext(1, 1, 22'h30000B, 8'h5F, 0, 0);
    ext(1, 1, 22'h300006, 8'hFF, 1, 0);
    ext(0, 3, 22'h000100, 0, 1, 0);
    ext(2, 3, 22'h000100, 0, 1, 0);
    chk(rowCnt, 0);
    ext(0, 2, 22'h200008, 0, 1, 0);
    ext(0, 2, 22'h200003, 0, 0, 8'hA6);
    chk({memTgt_r, memAddr_r[5:0]}, 8'h83);
    prog_u.frame(lb, oeLow, oeRel);
    chk(lb, 8'hA6);
    chk({oeLow, oeRel}, 3);
    mclrHighVoltage = 1'b0;
    progModeEntryPin = 1'b1;
    idle(8);
    chk(progMode_r, 0);
    cpu(1, 22'h000020, 8'h44);
    chk({wrCnt[6:0], srcExt}, 8'h04);
    cpu(1, 22'h30000B, 8'hFF);
    cpu(0, 22'h30000B, 8'h00);
    chk(cpuCfgRdData_r, 8'h5F);
    cpu(1, 22'h200000, 8'h55);
    chk(wrCnt, 3);
    chk({memTgt_r, memWdata_r[5:0]}, 8'h95);
    report_and_stop;
  end
endmodule // ppp_protect_ctrl_test
